//--- core/wdu_pkg.sv
// Package for the watchdog unit: register map, field positions, reset values, states.
// Assumes a 32-bit APB slave at byte addresses on a 100 MHz pclk.
package wdu_pkg;

  localparam int unsigned PCLK_HZ         = 100_000_000;
  localparam int unsigned WATCHDOG_CLOCK_HZ        = 2_000_000;
  localparam int unsigned WATCHDOG_CLOCK_DIV       = PCLK_HZ / WATCHDOG_CLOCK_HZ;
  localparam logic [5:0]  WATCHDOG_CLOCK_DIV_LAST  = 6'(WATCHDOG_CLOCK_DIV - 1);
  localparam logic [1:0]  PRESCALE_LAST   = 2'h3;
  localparam logic [23:0] RELOAD_FLOOR    = 24'h00_00FF;
  localparam logic [23:0] RELOAD_RESET    = 24'hFF_FFFF;
  localparam logic [7:0]  FEED_KEY1       = 8'hAA;
  localparam logic [7:0]  FEED_KEY2       = 8'h55;
  localparam logic [7:0]  RESET_PULSE_LEN = 8'h10;

  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_RELOAD = 12'h004;
  localparam logic [11:0] OFF_FEED   = 12'h008;
  localparam logic [11:0] OFF_COUNT  = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_RST_BIT  = 1;
  localparam int unsigned CTRL_CLK_BIT  = 2;
  localparam int unsigned STAT_RST_BIT  = 0;
  localparam int unsigned STAT_IRQ_BIT  = 1;

  typedef enum logic [1:0] {
    WDU_FEED_IDLE = 2'b00,
    WDU_FEED_KEY1 = 2'b01
  } wdu_feed_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdu_apb_req_s;

endpackage

//--- core/wdu_core.sv
// Watchdog unit: clock select, divide-by-4 prescaler, 24-bit down-counter, feed check, APB registers.
// Assumes the external watchdog clock arrives asynchronously and is much slower than pclk.
// Overview of operation
// - The watchdog clock is divided by four before it steps the 24-bit counter.
// - The counter decrements by one on each prescaled tick while the watchdog runs.
// - A reload value below 0xFF is replaced by 0xFF when loaded.
// - The timeout spans 256x4 to 2^24x4 watchdog clock periods in steps of four periods.
// - Software must reload before the interval runs out, otherwise a system reset or an interrupt is raised, chosen by the reset-select bit.
// - Software can set the enable, which then holds until a hardware reset or a watchdog event.
// - A wrong or unfinished feed sequence while enabled raises a reset or an interrupt.
// - A readable flag records that the last reset came from the watchdog.
// - The watchdog clock is an internal 2 MHz tick or the external clock, chosen by a control bit.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module wdu_core
  import wdu_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire wdu_pkg::wdu_apb_req_s apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ext_watchdog_clock,
  output logic                       wdu_sys_reset,
  output logic                       wdu_irq
);
  import wdu_pkg::*;

  logic [2:0]  ext_sync_q, ext_sync_d;
  logic [5:0]  div_q, div_d;
  logic [1:0]  pre_q, pre_d;
  logic [23:0] cnt_q, cnt_d;
  logic [23:0] reload_q, reload_d;
  logic        en_q, en_d;
  logic        rst_sel_q, rst_sel_d;
  logic        clk_sel_q, clk_sel_d;
  logic        rst_flag_q, rst_flag_d;
  logic        irq_flag_q, irq_flag_d;
  logic        irq_q, irq_d;
  logic [7:0]  rst_cnt_q, rst_cnt_d;
  logic        sysrst_q, sysrst_d;
  wdu_feed_e   feed_q, feed_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  logic        wd_tick, pre_tick, wr, rd, feed_wr, feed_ok, feed_bad, fire;
  logic [23:0] reload_val;

  always_comb begin
    ext_sync_d = {ext_sync_q[1:0], ext_watchdog_clock};
    div_d      = (div_q == WATCHDOG_CLOCK_DIV_LAST) ? 6'h00 : div_q + 6'h01;
    // Edge taken only from the second and third stages of the synchroniser
    wd_tick    = clk_sel_q ? (ext_sync_q[1] & ~ext_sync_q[2]) : (div_q == WATCHDOG_CLOCK_DIV_LAST);
    wr         = apb_req.psel & apb_req.penable & apb_req.pwrite & ~pready_q;
    rd         = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~pready_q;
    feed_wr    = wr & (apb_req.paddr == OFF_FEED);
    reload_val = (reload_q < RELOAD_FLOOR) ? RELOAD_FLOOR : reload_q;

    // Feed sequence: first key then second key on consecutive feed writes
    feed_d   = feed_q;
    feed_ok  = 1'b0;
    feed_bad = 1'b0;
    if (feed_wr && en_q) begin
      case (feed_q)
        WDU_FEED_IDLE: begin
          if (apb_req.pwdata[7:0] == FEED_KEY1) begin
            feed_d = WDU_FEED_KEY1;
          end else begin
            feed_bad = 1'b1;
          end
        end
        WDU_FEED_KEY1: begin
          feed_d = WDU_FEED_IDLE;
          if (apb_req.pwdata[7:0] == FEED_KEY2) begin
            feed_ok = 1'b1;
          end else begin
            feed_bad = 1'b1;
          end
        end
        default: feed_d = WDU_FEED_IDLE;
      endcase
    end else if (wr && en_q && feed_q == WDU_FEED_KEY1) begin
      // Any other register write between the two keys leaves the feed unfinished
      feed_bad = 1'b1;
      feed_d   = WDU_FEED_IDLE;
    end
    // A half-done sequence must not outlive an expiry, or the next first key would count as the second
    if (!en_q) begin
      feed_d = WDU_FEED_IDLE;
    end

    // Prescaler only runs while enabled so the interval starts at the enable boundary; a feed does not clear it
    pre_d    = en_q ? (wd_tick ? pre_q + 2'h1 : pre_q) : 2'h0;
    pre_tick = en_q & wd_tick & (pre_q == PRESCALE_LAST);
    fire     = (en_q & pre_tick & (cnt_q == 24'h00_0000)) | feed_bad;

    cnt_d = cnt_q;
    if (feed_ok || !en_q) begin
      cnt_d = reload_val;
    end else if (pre_tick && cnt_q != 24'h00_0000) begin
      cnt_d = cnt_q - 24'h00_0001;
    end

    en_d      = en_q;
    rst_sel_d = rst_sel_q;
    clk_sel_d = clk_sel_q;
    reload_d  = reload_q;
    if (wr && apb_req.paddr == OFF_CTRL) begin
      en_d      = en_q | apb_req.pwdata[CTRL_EN_BIT];
      if (!en_q) begin
        rst_sel_d = apb_req.pwdata[CTRL_RST_BIT];
        clk_sel_d = apb_req.pwdata[CTRL_CLK_BIT];
      end
    end
    if (wr && apb_req.paddr == OFF_RELOAD) begin
      reload_d = apb_req.pwdata[23:0];
    end
    if (fire) begin
      en_d = 1'b0;
    end

    // Status bits clear on write-one; a new event in the same cycle wins
    irq_flag_d = irq_flag_q;
    rst_flag_d = rst_flag_q;
    if (wr && apb_req.paddr == OFF_STATUS) begin
      irq_flag_d = irq_flag_q & ~apb_req.pwdata[STAT_IRQ_BIT];
      rst_flag_d = rst_flag_q & ~apb_req.pwdata[STAT_RST_BIT];
    end
    if (fire && !rst_sel_q) begin
      irq_flag_d = 1'b1;
    end
    if (fire && rst_sel_q) begin
      rst_flag_d = 1'b1;
    end
    irq_d = irq_flag_d;

    // Reset pulse of fixed length; the flag lives in this block so it survives the pulse
    rst_cnt_d = (rst_cnt_q != 8'h00) ? rst_cnt_q - 8'h01 : 8'h00;
    if (fire && rst_sel_q) begin
      rst_cnt_d = RESET_PULSE_LEN;
    end
    sysrst_d = (rst_cnt_d != 8'h00);
  end

  // Read port; reads carry no side effect, so STATUS and COUNT can be polled at any time
  always_comb begin
    pready_d  = apb_req.psel & apb_req.penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (rd) begin
      case (apb_req.paddr)
        OFF_CTRL:   prdata_d = {29'h0000_0000, clk_sel_q, rst_sel_q, en_q};
        OFF_RELOAD: prdata_d = {8'h00, reload_q};
        OFF_FEED:   prdata_d = 32'h0000_0000;
        OFF_COUNT:  prdata_d = {8'h00, cnt_q};
        OFF_STATUS: prdata_d = {30'h0000_0000, irq_flag_q, rst_flag_q};
        default:    pslverr_d = 1'b1;
      endcase
    end
    if (wr) begin
      case (apb_req.paddr)
        OFF_CTRL, OFF_RELOAD, OFF_FEED, OFF_STATUS: pslverr_d = 1'b0;
        default:                                    pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_q <= 3'h0;
      div_q      <= 6'h00;
      pre_q      <= 2'h0;
      cnt_q      <= RELOAD_RESET;
      reload_q   <= RELOAD_RESET;
      en_q       <= 1'b0;
      rst_sel_q  <= 1'b0;
      clk_sel_q  <= 1'b0;
      rst_flag_q <= 1'b0;
      irq_flag_q <= 1'b0;
      irq_q      <= 1'b0;
      rst_cnt_q  <= 8'h00;
      sysrst_q   <= 1'b0;
      feed_q     <= WDU_FEED_IDLE;
    end else begin
      ext_sync_q <= ext_sync_d;
      div_q      <= div_d;
      pre_q      <= pre_d;
      cnt_q      <= cnt_d;
      reload_q   <= reload_d;
      en_q       <= en_d;
      rst_sel_q  <= rst_sel_d;
      clk_sel_q  <= clk_sel_d;
      rst_flag_q <= rst_flag_d;
      irq_flag_q <= irq_flag_d;
      irq_q      <= irq_d;
      rst_cnt_q  <= rst_cnt_d;
      sysrst_q   <= sysrst_d;
      feed_q     <= feed_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign wdu_sys_reset = sysrst_q;
  assign wdu_irq       = irq_q;

endmodule

//--- sim/wdu_props.sv
// Checker for the watchdog unit ports.
// Assumes one pclk domain; bound onto wdu_core.
`timescale 1ns/100ps
module wdu_props
  import wdu_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire wdu_pkg::wdu_apb_req_s apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  wdu_sys_reset,
  input wire logic                  wdu_irq
);
  logic tk;
  logic rd;
  logic clr;
  assign tk = apb_req.psel && apb_req.penable && !pready;
  assign rd = tk && !apb_req.pwrite;
  assign clr = tk && apb_req.pwrite && apb_req.paddr == OFF_STATUS && apb_req.pwdata[STAT_IRQ_BIT];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_hi8;
    wdu_sys_reset [*8];
  endsequence
  property p_rdy; tk |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_feed; rd && apb_req.paddr == OFF_FEED |=> prdata == 32'h0; endproperty
  property p_cnt; rd && apb_req.paddr == OFF_COUNT |=> prdata[31:24] == 8'h0; endproperty
  property p_pulse; $rose(wdu_sys_reset) |-> s_hi8 ##1 s_hi8 ##1 !wdu_sys_reset; endproperty
  // Sticky until software writes one to clear it
  property p_irq; wdu_irq && !clr |=> wdu_irq; endproperty
  property p_quiet; $rose(presetn) |-> !pready && !wdu_sys_reset && !wdu_irq; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing");
  a_one: assert property (p_one) else $error("pready too long");
  a_err: assert property (p_err) else $error("bad pslverr");
  a_feed: assert property (p_feed) else $error("feed read not zero");
  a_cnt: assert property (p_cnt) else $error("count wider than 24");
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  a_irq: assert property (p_irq) else $error("irq dropped");
  a_quiet: assert property (p_quiet) else $error("outputs after reset");
endmodule
bind wdu_core wdu_props i_wdu_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wdu_sys_reset(wdu_sys_reset), .wdu_irq(wdu_irq));

//--- sim/test_watchdog_timer_core.sv
// Bench for the watchdog unit: APB master tasks, one task per scenario.
// Assumes an APB slave that answers with pready; makes a pclk/8 external watchdog clock.
`timescale 1ns/100ps
module test_watchdog_timer_core;
  import wdu_pkg::*;
  logic         pclk, presetn, pready, pslverr, srst, irq, err;
  logic         xclk = 1'b0;
  logic [31:0]  prdata, rd;
  wdu_apb_req_s req;
  int           n_errors = 0;
  int           comparisons = 0;
  int           cyc = 0;
  int           k;
  wdu_core i_wdu_core (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_watchdog_clock(xclk), .wdu_sys_reset(srst), .wdu_irq(irq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // External clock well under pclk/4 so the synchroniser sees every edge
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    xclk <= cyc[2];
    if (cyc == 30000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) n_errors++;
    if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_regs();
    rc(OFF_RELOAD, 32'h00FF_FFFF);
    rc(OFF_COUNT, 32'h00FF_FFFF);
    rc(OFF_STATUS, 32'h0);
    rc(12'h100, 32'h0);
    chk(err, 32'h1);
    xf(1'b1, OFF_RELOAD, 32'hFE);
    rc(OFF_COUNT, 32'hFF);
  endtask
  task automatic t_feed();
    xf(1'b1, OFF_CTRL, 32'h4);
    xf(1'b1, OFF_CTRL, 32'h5);
    xf(1'b1, OFF_CTRL, 32'h0);
    rc(OFF_CTRL, 32'h5);
    rc(OFF_FEED, 32'h0);
    xf(1'b1, OFF_FEED, 32'hAA);
    xf(1'b1, OFF_FEED, 32'h55);
    chk(irq, 32'h0);
    xf(1'b1, OFF_FEED, 32'hAA);
    xf(1'b1, OFF_FEED, 32'h12);
    chk({srst, irq}, 32'h1);
    rc(OFF_STATUS, 32'h2);
    rc(OFF_CTRL, 32'h4);
    xf(1'b1, OFF_STATUS, 32'h2);
    chk(irq, 32'h0);
    xf(1'b1, OFF_CTRL, 32'h5);
    xf(1'b1, OFF_FEED, 32'hAA);
    xf(1'b1, OFF_RELOAD, 32'hFE);
    chk({srst, irq}, 32'h1);
    rc(OFF_CTRL, 32'h4);
    xf(1'b1, OFF_STATUS, 32'h2);
    chk(irq, 32'h0);
  endtask
  task automatic t_expire();
    xf(1'b1, OFF_CTRL, 32'h6);
    xf(1'b1, OFF_CTRL, 32'h7);
    // First key left pending across the expiry must not linger into the next enable
    xf(1'b1, OFF_FEED, 32'hAA);
    k = 0;
    while (srst !== 1'b1 && k < 9000) begin
      @(posedge pclk);
      k++;
    end
    // Slack covers synchroniser delay and tick and prescaler phase
    chk(32'(k > 8150 && k < 8210), 32'h1);
    repeat (20) @(posedge pclk);
    rc(OFF_STATUS, 32'h1);
    rc(OFF_CTRL, 32'h6);
    xf(1'b1, OFF_CTRL, 32'h3);
    xf(1'b1, OFF_FEED, 32'hAA);
    xf(1'b1, OFF_FEED, 32'h55);
    chk({srst, irq}, 32'h0);
    repeat (2000) @(posedge pclk);
    xf(1'b0, OFF_COUNT, 32'h0);
    chk(32'(rd > 32'hF3 && rd < 32'hF7), 32'h1);
  endtask
  initial begin
    presetn = 1'b0;
    req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_feed();
    t_expire();
    end_of_test();
  end
endmodule
